// [rtl/allcall_defs.svh]
// Constants for the all-call reply and lockout logic
`ifndef ALLCALL_DEFS_SVH
`define ALLCALL_DEFS_SVH

// Uplink and downlink format codes
`define UF_SURV_ALT     5'h04
`define UF_SURV_ID      5'h05
`define UF_ALLCALL      5'h0b
`define UF_COMMA_ALT    5'h14
`define UF_COMMA_ID     5'h15
`define DF_SURV_ALT     5'h04
`define DF_SURV_ID      5'h05
`define DF_ALLCALL      5'h0b
`define DF_COMMB_ALT    5'h14
`define DF_COMMB_ID     5'h15
`define RR_COMMB_MIN    5'h10

// Designator codes and special designator layout
`define DI_MULTISITE    3'h1
`define DI_LOCKOUT_EDR  3'h7
`define SD_IIS_HI       15
`define SD_IIS_LO       12
`define SD_LOS_BIT      6

// Reply probability code ranges
`define PR_STOCH_MAX    4'h4
`define PR_OVR_MIN      4'h8
`define PR_OVR_MAX      4'h0c

// Flight status codes
`define FS_ALERT        3'h2
`define FS_NORMAL_HI    2'h0

// Timing figures and derived cycle and tick counts
`define CLK_MHZ         125
`define US_PER_S        1000000
`define TURNAROUND_US   128
`define TURN_CYC        (`TURNAROUND_US * `CLK_MHZ)
`define TICK_US         1000
`define TICK_CYC        (`TICK_US * `CLK_MHZ)
`define LOCKOUT_S       18
`define ALERT_S         18
`define LOCK_TICKS      (`LOCKOUT_S * `US_PER_S / `TICK_US)
`define ALERT_TICKS     (`ALERT_S * `US_PER_S / `TICK_US)

// Widths
`define TURN_W          16
`define TICK_W          17
`define TMR_W           15
`define SITES           16
`define SITE_W          4

// Register map
`define REG_CTRL        4'h0
`define REG_AA          4'h1
`define REG_MODEA       4'h2
`define REG_STATUS      4'h3
`define CTRL_W          5
`define CTRL_EN_BIT     0
`define CTRL_CA_HI      3
`define CTRL_CA_LO      1
`define CTRL_GND_BIT    4
`define CTRL_RST        5'h01
`define MODEA_W         14
`define MODEA_CODE_HI   12
`define MODEA_EMERG_BIT 13
`define STAT_ALERT_BIT  16
`define LFSR_SEED       16'hace1

`endif

// [rtl/allcall_pkg.sv]
// Types shared by the all-call reply and lockout logic
`include "allcall_defs.svh"
package allcall_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } st_type;

  typedef struct packed {
    st_type                   st;
    logic [`TURN_W-1:0]       wait_cnt;
    logic [`TICK_W-1:0]       tick_cnt;
    logic                     tick;
    logic [15:0]              lfsr;
    logic [`TMR_W-1:0]        alert_cnt;
    logic                     alert;
    logic [`CTRL_W-1:0]       ctrl;
    logic [23:0]              aa;
    logic [`MODEA_W-1:0]      mode_a;
    logic [31:0]              rdata;
    logic                     lk_set;
    logic [`SITE_W-1:0]       lk_site;
    logic [4:0]               pend_df;
    logic [`SITE_W-1:0]       pend_ii;
    logic                     rvalid;
    logic [4:0]               rdf;
    logic [2:0]               rfs;
    logic [23:0]              rpi;
  } core_type;

  typedef struct packed {
    logic [`SITES-1:0][`TMR_W-1:0] cnt;
  } bank_type;

endpackage

// [rtl/lockout_if.sv]
// Carrier between the reply core and its lockout timer bank
`timescale 1ns/1ps
`include "allcall_defs.svh"
interface lockout_if;
  logic                set;
  logic [`SITE_W-1:0]  set_site;
  logic [`SITES-1:0]   active;

  modport core (output set, output set_site, input active);
  modport bank (input set, input set_site, output active);
endinterface

// [rtl/lockout_bank.sv]
// Sixteen independent site lockout timers counted in millisecond ticks
`timescale 1ns/1ps
`include "allcall_defs.svh"
module lockout_bank #(
  parameter logic [`TMR_W-1:0] LOCK_TICKS = `TMR_W'(`LOCK_TICKS)
) (
  input  wire logic  mclk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  tick_i,
  lockout_if.bank    lk
);

  allcall_pkg::bank_type q;
  allcall_pkg::bank_type n;

  // Reload beats decrement, so a refresh in a tick cycle still restarts
  always_comb begin
    n = q;
    for (int i = 0; i < `SITES; i++) begin
      if (lk.set && lk.set_site == `SITE_W'(i)) begin
        n.cnt[i] = LOCK_TICKS;
      end else if (tick_i && q.cnt[i] != '0) begin
        n.cnt[i] = q.cnt[i] - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // One lockout flag per timer, site zero is the non-selective one
  for (genvar g = 0; g < `SITES; g++) begin : g_act
    assign lk.active[g] = (q.cnt[g] != '0);
  end

  AST_LOCK_LOAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    lk.set |=> q.cnt[$past(lk.set_site)] == LOCK_TICKS)
    else $error("lockout timer not reloaded to full span");

  AST_LOCK_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!tick_i && !lk.set && q.cnt[0] != '0) |=> $stable(q.cnt[0]))
    else $error("lockout timer moved without a tick");

endmodule

// [rtl/allcall_reply_core.sv]
// All-call reply decision, site lockout, roll-call format choice and alert
`timescale 1ns/1ps
`include "allcall_defs.svh"
module allcall_reply_core #(
  parameter logic [`TICK_W-1:0] TICK_CYC    = `TICK_W'(`TICK_CYC),
  parameter logic [`TURN_W-1:0] TURN_CYC    = `TURN_W'(`TURN_CYC),
  parameter logic [`TMR_W-1:0]  LOCK_TICKS  = `TMR_W'(`LOCK_TICKS),
  parameter logic [`TMR_W-1:0]  ALERT_TICKS = `TMR_W'(`ALERT_TICKS)
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         req_valid_i,
  input  wire logic [4:0]   req_uf_i,
  input  wire logic [3:0]   req_ii_i,
  input  wire logic [3:0]   req_pr_i,
  input  wire logic [4:0]   req_rr_i,
  input  wire logic [2:0]   req_di_i,
  input  wire logic [15:0]  req_sd_i,
  input  wire logic [3:0]   reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  output logic      [31:0]  reg_rdata_o,
  output logic              busy_o,
  output logic              reply_valid_o,
  output logic      [4:0]   reply_df_o,
  output logic      [2:0]   reply_fs_o,
  output logic      [2:0]   reply_ca_o,
  output logic      [23:0]  reply_aa_o,
  output logic      [23:0]  reply_pi_addr_o
);

  allcall_pkg::core_type q;
  allcall_pkg::core_type n;
  lockout_if             lk_bus();

  // Roll-call formats that always elicit a reply
  function automatic logic is_roll(input logic [4:0] uf);
    is_roll = (uf == `UF_SURV_ALT) || (uf == `UF_SURV_ID) ||
              (uf == `UF_COMMA_ALT) || (uf == `UF_COMMA_ID);
  endfunction

  // Identity requests map to the identity downlink pair
  function automatic logic is_ident(input logic [4:0] uf);
    is_ident = (uf == `UF_SURV_ID) || (uf == `UF_COMMA_ID);
  endfunction

  // Low k bits of the LFSR all zero gives odds of one in two to the k
  function automatic logic trial_pass(input logic [15:0] r, input logic [2:0] k);
    logic [15:0] mask;
    mask = (16'h0001 << k) - 16'h0001;
    trial_pass = ((r & mask) == 16'h0000);
  endfunction

  // Lockout command carried in the special designator
  function automatic logic is_lock_cmd(input logic [2:0] di, input logic [15:0] sd);
    is_lock_cmd = ((di == `DI_MULTISITE) || (di == `DI_LOCKOUT_EDR)) && sd[`SD_LOS_BIT];
  endfunction

  // Next-state logic for the whole core
  always_comb begin
    logic        roll;
    logic        allc;
    logic        locked;
    logic        allc_ok;
    logic        code_chg;
    logic [4:0]  df;
    roll     = is_roll(req_uf_i);
    allc     = (req_uf_i == `UF_ALLCALL);
    locked   = lk_bus.active[req_ii_i];
    allc_ok  = 1'b0;
    code_chg = 1'b0;
    df       = `DF_ALLCALL;
    n        = q;
    n.lk_set = 1'b0;
    n.rvalid = 1'b0;
    n.rdata  = 32'h0000_0000;

    // Free-running LFSR steps every cycle so each request sees a new draw
    n.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[14] ^ q.lfsr[12] ^ q.lfsr[3]};

    // Millisecond tick shared by lockout and alert timers
    if (q.tick_cnt == TICK_CYC - 1'b1) begin
      n.tick_cnt = '0;
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt + 1'b1;
      n.tick     = 1'b0;
    end

    // Register writes; status is read-only
    if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_CTRL:  n.ctrl = reg_wdata_i[`CTRL_W-1:0];
        `REG_AA:    n.aa   = reg_wdata_i[23:0];
        `REG_MODEA: begin
          n.mode_a = reg_wdata_i[`MODEA_W-1:0];
          code_chg = reg_wdata_i[`MODEA_CODE_HI:0] != q.mode_a[`MODEA_CODE_HI:0];
        end
        default: ;
      endcase
    end

    // Alert timer: a fresh code change reloads, ticks wind it down
    if (code_chg) begin
      n.alert_cnt = ALERT_TICKS;
    end else if (q.tick && q.alert_cnt != '0) begin
      n.alert_cnt = q.alert_cnt - 1'b1;
    end
    n.alert = n.mode_a[`MODEA_EMERG_BIT] || (n.alert_cnt != '0);

    // Register reads: data stand only in the cycle after the strobe
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CTRL:   n.rdata = {27'h000_0000, q.ctrl};
        `REG_AA:     n.rdata = {8'h00, q.aa};
        `REG_MODEA:  n.rdata = {18'h0_0000, q.mode_a};
        `REG_STATUS: n.rdata = {15'h0000, q.alert, lk_bus.active};
        default:     n.rdata = 32'h0000_0000;
      endcase
    end

    // Reply decision per all-call probability class
    if (req_pr_i <= `PR_STOCH_MAX) begin
      allc_ok = !locked && trial_pass(q.lfsr, req_pr_i[2:0]);
    end else if (req_pr_i >= `PR_OVR_MIN && req_pr_i <= `PR_OVR_MAX) begin
      allc_ok = trial_pass(q.lfsr, req_pr_i[2:0]);
    end
    if (roll) begin
      df = is_ident(req_uf_i) ? ((req_rr_i < `RR_COMMB_MIN) ? `DF_SURV_ID : `DF_COMMB_ID)
                              : ((req_rr_i < `RR_COMMB_MIN) ? `DF_SURV_ALT : `DF_COMMB_ALT);
    end

    // Sequencer: new requests are ignored while a reply is pending
    unique case (q.st)
      allcall_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          if (is_lock_cmd(req_di_i, req_sd_i)) begin
            n.lk_set  = 1'b1;
            n.lk_site = req_sd_i[`SD_IIS_HI:`SD_IIS_LO];
          end
          if (q.ctrl[`CTRL_EN_BIT] && (roll || (allc && allc_ok))) begin
            n.st       = allcall_pkg::ST_WAIT;
            n.wait_cnt = TURN_CYC - 1'b1;
            n.pend_df  = df;
            n.pend_ii  = req_ii_i;
          end
        end
      end
      allcall_pkg::ST_WAIT: begin
        if (q.wait_cnt == '0) begin
          n.st     = allcall_pkg::ST_IDLE;
          n.rvalid = 1'b1;
          n.rdf    = q.pend_df;
          n.rfs    = q.alert ? `FS_ALERT
                             : {`FS_NORMAL_HI, q.ctrl[`CTRL_GND_BIT]};
          n.rpi    = (q.pend_df == `DF_ALLCALL) ? {20'h0_0000, q.pend_ii} : 24'h00_0000;
        end else begin
          n.wait_cnt = q.wait_cnt - 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q         <= '0;
      q.st      <= allcall_pkg::ST_IDLE;
      q.ctrl    <= `CTRL_RST;
      q.lfsr    <= `LFSR_SEED;
    end else begin
      q <= n;
    end
  end

  // Timer bank hookup
  assign lk_bus.set      = q.lk_set;
  assign lk_bus.set_site = q.lk_site;

  lockout_bank #(
    .LOCK_TICKS (LOCK_TICKS)
  ) u_bank (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .tick_i     (q.tick),
    .lk         (lk_bus)
  );

  // Outputs straight from flops; CA and AA are live register fields
  assign reg_rdata_o     = q.rdata;
  assign busy_o          = (q.st == allcall_pkg::ST_WAIT);
  assign reply_valid_o   = q.rvalid;
  assign reply_df_o      = q.rdf;
  assign reply_fs_o      = q.rfs;
  assign reply_ca_o      = q.ctrl[`CTRL_CA_HI:`CTRL_CA_LO];
  assign reply_aa_o      = q.aa;
  assign reply_pi_addr_o = q.rpi;

  // Checks
  logic accept;
  assign accept = (q.st == allcall_pkg::ST_IDLE) && req_valid_i;

  sequence s_allc_take(logic [3:0] pr);
    accept && q.ctrl[`CTRL_EN_BIT] && req_uf_i == `UF_ALLCALL && req_pr_i == pr;
  endsequence

  sequence s_launch;
    accept && (q.st == allcall_pkg::ST_IDLE) ##1 (q.st == allcall_pkg::ST_WAIT);
  endsequence

  AST_TURN_LOAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_launch |-> q.wait_cnt == TURN_CYC - 1'b1)
    else $error("turnaround count not loaded");

  AST_TURN_END: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    reply_valid_o |-> $past(q.st) == allcall_pkg::ST_WAIT && $past(q.wait_cnt) == '0)
    else $error("reply left before turnaround ended");

  AST_LOCK_SUPP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_allc_take(4'h0) and (lk_bus.active[req_ii_i])) |=> q.st == allcall_pkg::ST_IDLE)
    else $error("locked-out site answered");

  AST_OVERRIDE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_allc_take(4'h8) |=> q.st == allcall_pkg::ST_WAIT)
    else $error("override all-call not answered");

  AST_PROB_HALF: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_allc_take(4'h1) and (q.lfsr[0])) |=> q.st == allcall_pkg::ST_IDLE)
    else $error("half-odds trial answered on losing draw");

  AST_PI_ADDR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (reply_valid_o && reply_df_o == `DF_ALLCALL) |-> reply_pi_addr_o[23:4] == 20'h0_0000)
    else $error("pseudo address not zero-filled");

  AST_ROLL_DF: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (accept && q.ctrl[`CTRL_EN_BIT] && req_uf_i == `UF_COMMA_ALT && req_rr_i >= `RR_COMMB_MIN)
    |=> q.pend_df == `DF_COMMB_ALT)
    else $error("wrong downlink format for high reply request");

  AST_ALERT_FS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (q.st == allcall_pkg::ST_WAIT && q.wait_cnt == '0 && q.alert) |=> reply_fs_o == `FS_ALERT)
    else $error("alert not reported in flight status");

  AST_EMERG: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    q.mode_a[`MODEA_EMERG_BIT] |-> q.alert)
    else $error("emergency code without alert");

  AST_LOCK_CMD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (accept && is_lock_cmd(req_di_i, req_sd_i)) |=> q.lk_set ##1 lk_bus.active[q.lk_site])
    else $error("lockout command did not lock the site");

endmodule

// [tb/sensor_model.sv]
// Ground interrogator model driving decoded uplink interrogation fields
`timescale 1ns/1ps
module sensor_model (
  input  wire logic        mclk_i,
  input  wire logic        busy_i,
  output logic             req_valid_o,
  output logic [4:0]       req_uf_o,
  output logic [3:0]       req_ii_o,
  output logic [3:0]       req_pr_o,
  output logic [4:0]       req_rr_o,
  output logic [2:0]       req_di_o,
  output logic [15:0]      req_sd_o
);
  logic        vld_r = 1'b0;
  logic [36:0] f_r   = '0;
  logic [36:0] scr_r = 37'h0_5555_5555;

  // Fields mean nothing outside the request cycle, so they churn there
  always @(posedge mclk_i) scr_r <= ~scr_r;
  assign req_valid_o = vld_r;
  assign {req_uf_o, req_ii_o, req_pr_o, req_rr_o, req_di_o, req_sd_o} = vld_r ? f_r : scr_r;

  // One interrogation, one cycle long, never while a reply is pending
  task automatic send(input logic [4:0] uf, input logic [3:0] ii, input logic [3:0] pr,
                      input logic [4:0] rr, input logic [2:0] di, input logic [15:0] sd);
    @(posedge mclk_i);
    while (busy_i === 1'b1) @(posedge mclk_i);
    vld_r <= 1'b1;
    f_r   <= {uf, ii, pr, rr, di, sd};
    @(posedge mclk_i);
    vld_r <= 1'b0;
  endtask
endmodule

// [tb/tb_allcall_reply_lockout_logic.sv]
// Self-checking bench for the all-call reply and lockout logic
`timescale 1ns/1ps
`include "allcall_defs.svh"
module tb_allcall_reply_lockout_logic;
  localparam int TURN = 4;
  localparam int TICK = 10;
  localparam int LTKS = 20;
  logic        mclk_i    = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        req_valid, busy, rvalid;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [3:0]  addr      = 4'h0;
  logic [31:0] wdata     = '0;
  logic [4:0]  uf, rr, df, gdf, u5, r5;
  logic [3:0]  ii, pr, s, s2;
  logic [2:0]  di, fs, ca, gfs;
  logic [15:0] sd;
  logic [23:0] aa, pi, gpi, aa_w;
  logic [31:0] rdata, rv;
  logic [12:0] code;
  logic        got;
  logic [4:0]  ufs [4] = '{`UF_SURV_ALT, `UF_SURV_ID, `UF_COMMA_ALT, `UF_COMMA_ID};
  int          seed = 57203;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          glat, n, k, e;

  sensor_model u_sensor (.mclk_i(mclk_i), .busy_i(busy), .req_valid_o(req_valid),
    .req_uf_o(uf), .req_ii_o(ii), .req_pr_o(pr), .req_rr_o(rr), .req_di_o(di), .req_sd_o(sd));

  // Short tick and timers keep the run small; expectations use the same figures
  allcall_reply_core #(.TICK_CYC(`TICK_W'(TICK)), .TURN_CYC(`TURN_W'(TURN)),
    .LOCK_TICKS(`TMR_W'(LTKS)), .ALERT_TICKS(`TMR_W'(LTKS))) u_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid), .req_uf_i(uf),
    .req_ii_i(ii), .req_pr_i(pr), .req_rr_i(rr), .req_di_i(di), .req_sd_i(sd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .busy_o(busy), .reply_valid_o(rvalid), .reply_df_o(df),
    .reply_fs_o(fs), .reply_ca_o(ca), .reply_aa_o(aa), .reply_pi_addr_o(pi));

  initial forever #4 mclk_i = ~mclk_i;

  // Hang guard, generous over the expected run
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end

  function automatic logic [4:0] exp_df(input logic [4:0] u, input logic [4:0] r);
    if (u == `UF_SURV_ALT || u == `UF_COMMA_ALT) return (r < 5'h10) ? `DF_SURV_ALT : `DF_COMMB_ALT;
    return (r < 5'h10) ? `DF_SURV_ID : `DF_COMMB_ID;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    total_checks++;
    if (ex !== sn) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, sn);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int sn);
    total_checks++;
    if (sn < lo || sn > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, sn);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    reg_rd <= 1'b1;
    addr   <= a;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  // Send one interrogation and watch every cycle for the reply pulse
  task automatic ask(input logic [4:0] u, input logic [3:0] i, input logic [3:0] p,
                     input logic [4:0] r, input logic [2:0] d, input logic [15:0] sdv);
    got  = 1'b0;
    glat = 0;
    u_sensor.send(u, i, p, r, d, sdv);
    // Count from the taking edge, so the reply lands at TURN
    for (int c = 0; c <= TURN + 2; c++) begin
      #1;
      if (rvalid === 1'b1) begin
        got  = 1'b1;
        glat = c;
        gdf  = df;
        gfs  = fs;
        gpi  = pi;
      end
      @(posedge mclk_i);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // Reset map, unmapped places read zero, status ignores writes
    for (int a = 0; a < 6; a++) begin
      rd(4'(a));
      chk("reset_reg", (a == 0) ? 32'h0000_0001 : 32'h0000_0000, rv);
    end
    wr(`REG_STATUS, 32'hffff_ffff);
    rd(`REG_STATUS);
    chk("status_ro", 32'h0000_0000, rv);
    aa_w = 24'($random(seed));
    wr(`REG_AA, {8'h00, aa_w});
    wr(`REG_CTRL, 32'h0000_000b);
    rd(`REG_AA);
    chk("aa_reg", {8'h00, aa_w}, rv);
    chk("ca", 3'h5, ca);
    chk("aa", aa_w, aa);
    // Roll-call formats, RR on both sides of 16 and at random
    for (int j = 0; j < 12; j++) begin
      u5 = ufs[j % 4];
      r5 = (j < 4) ? 5'h0f : (j < 8) ? 5'h10 : 5'($random(seed));
      ask(u5, 4'h0, 4'h0, r5, 3'h0, 16'h0000);
      chk("turnaround", TURN, glat);
      chk("rc_df", exp_df(u5, r5), gdf);
      chk("rc_fs", 3'h0, gfs);
      chk("rc_pi", 24'h00_0000, gpi);
    end
    s  = 4'($random(seed)) | 4'h1;
    s2 = s ^ 4'h2;
    ask(`UF_ALLCALL, s, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("ac_df", `DF_ALLCALL, gdf);
    chk("ac_pi", {20'h0_0000, s}, gpi);
    // Lockout by DI 7 and DI 1; DI 0 carries a site but never locks
    ask(`UF_SURV_ALT, 4'h0, 4'h0, 5'h00, `DI_LOCKOUT_EDR, {s, 5'h00, 1'b1, 6'h00});
    ask(`UF_SURV_ID, 4'h0, 4'h0, 5'h00, `DI_MULTISITE, {s2, 5'h00, 1'b1, 6'h00});
    ask(`UF_SURV_ID, 4'h0, 4'h0, 5'h00, 3'h0, {s ^ 4'h4, 5'h00, 1'b1, 6'h00});
    ask(`UF_SURV_ALT, 4'h0, 4'h0, 5'h00, `DI_LOCKOUT_EDR, 16'h0040);
    rd(`REG_STATUS);
    chk("lock_bits", (32'h1 << s) | (32'h1 << s2) | 32'h1, rv);
    ask(`UF_ALLCALL, s, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("locked", 1'b0, got);
    ask(`UF_ALLCALL, 4'h0, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("nonsel_locked", 1'b0, got);
    ask(`UF_ALLCALL, s, 4'h8, 5'h00, 3'h0, 16'h0000);
    chk("override", 1'b1, got);
    ask(`UF_ALLCALL, s ^ 4'h4, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("other_site", 1'b1, got);
    // One acquisition dwell of five all-calls to an unlocked site
    n = 0;
    for (int t = 0; t < 5; t++) begin
      ask(`UF_ALLCALL, s ^ 4'h4, 4'h0, 5'h00, 3'h0, 16'h0000);
      n += int'(got);
    end
    chk_rng("dwell", 5, 5, n);
    // Lock one site again after both have lapsed; the other stays clear
    repeat (120) @(posedge mclk_i);
    ask(`UF_SURV_ALT, 4'h0, 4'h0, 5'h00, `DI_LOCKOUT_EDR, {s, 5'h00, 1'b1, 6'h00});
    repeat (150) @(posedge mclk_i);
    rd(`REG_STATUS);
    chk("refreshed", 1'b1, rv[s]);
    chk("expired", 1'b0, rv[s2]);
    repeat (100) @(posedge mclk_i);
    rd(`REG_STATUS);
    chk("expired2", 1'b0, rv[s]);
    // Every PR code; reply counts must follow the commanded odds
    for (int p = 0; p < 16; p++) begin
      n = 0;
      for (int t = 0; t < 96; t++) begin
        ask(`UF_ALLCALL, s2, 4'(p), 5'h00, 3'h0, 16'h0000);
        n += int'(got);
      end
      k = p % 8;
      e = 96 >> k;
      if (k > 4) chk_rng("pr_never", 0, 0, n);
      else if (k == 0) chk_rng("pr_all", 96, 96, n);
      else chk_rng("pr_odds", (e / 4 > 0) ? e / 4 : 1, (e * 2 + 2 < 90) ? e * 2 + 2 : 90, n);
    end
    // Flight status: on ground, then alert after a code change
    wr(`REG_CTRL, 32'h0000_001b);
    ask(`UF_SURV_ALT, 4'h0, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("fs_ground", 3'h1, gfs);
    code = 13'($random(seed)) | 13'h0001;
    wr(`REG_MODEA, {19'h0_0000, code});
    ask(`UF_SURV_ID, 4'h0, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("fs_alert", `FS_ALERT, gfs);
    rd(`REG_STATUS);
    chk("alert_bit", 1'b1, rv[`STAT_ALERT_BIT]);
    repeat (230) @(posedge mclk_i);
    ask(`UF_COMMA_ALT, 4'h0, 4'h0, 5'h10, 3'h0, 16'h0000);
    chk("fs_timeout", 3'h1, gfs);
    wr(`REG_MODEA, {18'h0_0000, 1'b1, code ^ 13'h0002});
    repeat (300) @(posedge mclk_i);
    ask(`UF_COMMA_ID, 4'h0, 4'h0, 5'h10, 3'h0, 16'h0000);
    chk("fs_emerg", `FS_ALERT, gfs);
    // Reply enable off silences everything
    wr(`REG_CTRL, 32'h0000_0000);
    ask(`UF_SURV_ALT, 4'h0, 4'h0, 5'h00, 3'h0, 16'h0000);
    chk("disabled", 1'b0, got);
    results();
  end
endmodule
